// >>> logic/pbm_pkg.sv
// constants and carrier types for the port b/c/d/e alternate-function mux
package pbm_pkg;
	localparam logic [15:0] PBM_ADDR_IFACE_CFG = 16'he601;
	localparam logic [15:0] PBM_ADDR_FIFO2_CFG = 16'he618;
	localparam logic [15:0] PBM_ADDR_FIFO4_CFG = 16'he619;
	localparam logic [15:0] PBM_ADDR_FIFO6_CFG = 16'he61a;
	localparam logic [15:0] PBM_ADDR_FIFO8_CFG = 16'he61b;
	localparam logic [15:0] PBM_ADDR_PORT_C_SEL = 16'he671;
	localparam logic [15:0] PBM_ADDR_PORT_E_SEL = 16'he672;
	localparam logic [15:0] PBM_ADDR_DATA_B = 16'he6a0;
	localparam logic [15:0] PBM_ADDR_DATA_C = 16'he6a1;
	localparam logic [15:0] PBM_ADDR_DATA_D = 16'he6a2;
	localparam logic [15:0] PBM_ADDR_DATA_E = 16'he6a3;
	localparam logic [15:0] PBM_ADDR_OE_B = 16'he6a4;
	localparam logic [15:0] PBM_ADDR_OE_C = 16'he6a5;
	localparam logic [15:0] PBM_ADDR_OE_D = 16'he6a6;
	localparam logic [15:0] PBM_ADDR_OE_E = 16'he6a7;
	localparam logic [15:0] PBM_ADDR_PIN_STATUS = 16'he6a8;

	// interface configuration fields
	localparam int PBM_IFC_MODE_LO = 0;
	localparam int PBM_IFC_MODE_HI = 1;
	localparam int PBM_IFC_STATE_EN = 2;
	localparam logic [1:0] PBM_MODE_MASTER = 2'h2;
	// fifo configuration: word-width bit, and bits that read back as zero
	localparam int PBM_FCFG_WIDE = 0;
	localparam logic [7:0] PBM_FCFG_MASK = 8'h7d;
	localparam int PBM_NUM_FIFOS = 4;
	// port e pin positions
	localparam int PBM_PE_SER0 = 3;
	localparam int PBM_PE_SER1 = 4;
	localparam int PBM_PE_EXT_INTERRUPT_SIX = 5;
	localparam int PBM_PE_TIMER2_EXTERNAL_INPUT = 6;
	localparam int PBM_PE_ADDR8 = 7;
	// pin status register fields
	localparam int PBM_ST_B_FIFO = 0;
	localparam int PBM_ST_D_FIFO = 1;
	localparam int PBM_ST_STATE = 2;
	localparam int PBM_ST_ADDR_OK = 3;
	localparam logic [7:0] PBM_RESET_BYTE = 8'h00;

	// alternate outputs from the timer and serial blocks
	typedef struct packed {
		logic serial1_rx_output;
		logic serial0_rx_output;
		logic timer2_output;
		logic timer1_output;
		logic timer0_output;
	} pbm_alt_s;

	// one port's pin drive
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
	} pbm_pin_s;
endpackage

// >>> logic/pbm_pin_cell.sv
// per-pin selection between port register drive and alternate function drive
`timescale 1ns/100ps
module pbm_pin_cell #(
	parameter int WIDTH = 8
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] alt_sel,
	input wire logic [WIDTH-1:0] alt_val,
	input wire logic [WIDTH-1:0] alt_drive,
	input wire logic [WIDTH-1:0] gpio_val,
	input wire logic [WIDTH-1:0] gpio_oe,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe_n
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			// port register drive is cut off entirely on an alternate pin
			wire out_next = alt_sel[i] ? alt_val[i] : gpio_val[i];
			wire oe_n_next = alt_sel[i] ? ~alt_drive[i] : ~gpio_oe[i];
			always_ff @(posedge mclk)
			begin
				if (srst)
				begin
					pin_out[i] <= 1'b0;
					pin_oe_n[i] <= 1'b1;
				end
				else
				begin
					pin_out[i] <= out_next;
					pin_oe_n[i] <= oe_n_next;
				end
			end
		end
	endgenerate
endmodule // pbm_pin_cell

// >>> logic/pbm_port_mux.sv
// alternate-function pin mux for ports b, c, d and e with its register file
`timescale 1ns/100ps
module pbm_port_mux (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] port_b_in,
	output logic [7:0] port_b_out,
	output logic [7:0] port_b_oe_n,
	input wire logic [7:0] port_c_in,
	output logic [7:0] port_c_out,
	output logic [7:0] port_c_oe_n,
	input wire logic [7:0] port_d_in,
	output logic [7:0] port_d_out,
	output logic [7:0] port_d_oe_n,
	input wire logic [7:0] port_e_in,
	output logic [7:0] port_e_out,
	output logic [7:0] port_e_oe_n,
	input wire logic [15:0] fifo_data_bus_out,
	input wire logic fifo_data_bus_drive,
	output logic [15:0] fifo_data_bus_in,
	input wire logic [8:0] prog_iface_addr,
	input wire logic [2:0] iface_state,
	input wire pbm_pkg::pbm_alt_s alt_fn_out,
	output logic ext_interrupt_six,
	output logic timer2_external_input,
	output logic [1:0] iface_mode_field,
	output logic [3:0] fifo_16bit_sel
);
	logic [7:0] iface_cfg_reg;
	logic [7:0] fifo_cfg_reg [pbm_pkg::PBM_NUM_FIFOS];
	logic [7:0] port_c_sel_reg;
	logic [7:0] port_e_sel_reg;
	logic [7:0] data_b_reg;
	logic [7:0] data_c_reg;
	logic [7:0] data_d_reg;
	logic [7:0] data_e_reg;
	logic [7:0] oe_b_reg;
	logic [7:0] oe_c_reg;
	logic [7:0] oe_d_reg;
	logic [7:0] oe_e_reg;
	logic [7:0] rdata_reg;
	// two-stage synchronisers for all 32 pins; only the second stage is read
	logic [31:0] pin_meta_reg;
	logic [31:0] pin_sync_reg;

	wire [31:0] pin_raw = {port_e_in, port_d_in, port_c_in, port_b_in};
	wire [7:0] b_sync = pin_sync_reg[7:0];
	wire [7:0] c_sync = pin_sync_reg[15:8];
	wire [7:0] d_sync = pin_sync_reg[23:16];
	wire [7:0] e_sync = pin_sync_reg[31:24];

	// decoded configuration
	// mode 01 sets no upper bit, so it leaves ports b and d general
	wire mode_hi = iface_cfg_reg[pbm_pkg::PBM_IFC_MODE_HI];
	wire [1:0] mode_field = {mode_hi, iface_cfg_reg[pbm_pkg::PBM_IFC_MODE_LO]};
	wire state_en = iface_cfg_reg[pbm_pkg::PBM_IFC_STATE_EN];
	wire addr_valid = (mode_field == pbm_pkg::PBM_MODE_MASTER);
	wire [3:0] wide_bits;

	genvar f;
	generate
		for (f = 0; f < pbm_pkg::PBM_NUM_FIFOS; f++)
		begin : g_wide
			// each fifo's width comes only from its own register
			assign wide_bits[f] = fifo_cfg_reg[f][pbm_pkg::PBM_FCFG_WIDE];
		end
	endgenerate

	// port b follows the upper mode bit alone
	wire b_fifo = mode_hi;
	// port d needs a wide fifo too
	wire d_fifo = mode_hi & (|wide_bits);

	// address lines are forced low outside master mode rather than left
	// floating, so the pins stay deterministic
	wire [8:0] addr_gated = addr_valid ? prog_iface_addr : 9'h000;

	// port c: bit n carries address line n
	wire [7:0] c_alt_sel = port_c_sel_reg;
	wire [7:0] c_alt_val = addr_gated[7:0];

	// port e selection; no mode bits take part, so these pins behave the
	// same in every interface mode, except pin 7, whose address bit 8 is gated
	wire [2:0] e_low_sel = state_en ? 3'h7 : port_e_sel_reg[2:0];
	wire [2:0] e_timer_val = {alt_fn_out.timer2_output, alt_fn_out.timer1_output,
		alt_fn_out.timer0_output};
	// state outputs win over timer outputs on pins 2:0
	wire [2:0] e_low_val = state_en ? iface_state : e_timer_val;
	// pins 7:3 never depend on the state enable
	wire [7:0] e_alt_sel = {port_e_sel_reg[7:3], e_low_sel};
	// fixed pin order of port e alternate functions
	wire [7:0] e_alt_val;
	assign e_alt_val[2:0] = e_low_val;
	assign e_alt_val[pbm_pkg::PBM_PE_SER0] = alt_fn_out.serial0_rx_output;
	assign e_alt_val[pbm_pkg::PBM_PE_SER1] = alt_fn_out.serial1_rx_output;
	assign e_alt_val[pbm_pkg::PBM_PE_EXT_INTERRUPT_SIX] = 1'b0;
	assign e_alt_val[pbm_pkg::PBM_PE_TIMER2_EXTERNAL_INPUT] = 1'b0;
	// address bit 8 is gated the same way as port c
	assign e_alt_val[pbm_pkg::PBM_PE_ADDR8] = addr_gated[8];
	// pins 6 and 5 are alternate inputs, so the pin is released there
	wire [7:0] e_alt_drive = 8'h9f;

	// register bus decode
	wire sel_iface = (reg_addr == pbm_pkg::PBM_ADDR_IFACE_CFG);
	wire sel_f2 = (reg_addr == pbm_pkg::PBM_ADDR_FIFO2_CFG);
	wire sel_f4 = (reg_addr == pbm_pkg::PBM_ADDR_FIFO4_CFG);
	wire sel_f6 = (reg_addr == pbm_pkg::PBM_ADDR_FIFO6_CFG);
	wire sel_f8 = (reg_addr == pbm_pkg::PBM_ADDR_FIFO8_CFG);
	wire sel_csel = (reg_addr == pbm_pkg::PBM_ADDR_PORT_C_SEL);
	wire sel_esel = (reg_addr == pbm_pkg::PBM_ADDR_PORT_E_SEL);
	wire sel_db = (reg_addr == pbm_pkg::PBM_ADDR_DATA_B);
	wire sel_dc = (reg_addr == pbm_pkg::PBM_ADDR_DATA_C);
	wire sel_dd = (reg_addr == pbm_pkg::PBM_ADDR_DATA_D);
	wire sel_de = (reg_addr == pbm_pkg::PBM_ADDR_DATA_E);
	wire sel_ob = (reg_addr == pbm_pkg::PBM_ADDR_OE_B);
	wire sel_oc = (reg_addr == pbm_pkg::PBM_ADDR_OE_C);
	wire sel_od = (reg_addr == pbm_pkg::PBM_ADDR_OE_D);
	wire sel_oe = (reg_addr == pbm_pkg::PBM_ADDR_OE_E);
	wire sel_st = (reg_addr == pbm_pkg::PBM_ADDR_PIN_STATUS);
	wire [3:0] sel_fifo = {sel_f8, sel_f6, sel_f4, sel_f2};
	// bits 7 and 1 never store, so they always read back as zero
	wire [7:0] fifo_wdata = reg_wdata & pbm_pkg::PBM_FCFG_MASK;

	// status bits sit at fixed field positions; the upper nibble reads zero
	wire [7:0] pin_status;
	assign pin_status[7:4] = 4'h0;
	assign pin_status[pbm_pkg::PBM_ST_B_FIFO] = b_fifo;
	assign pin_status[pbm_pkg::PBM_ST_D_FIFO] = d_fifo;
	assign pin_status[pbm_pkg::PBM_ST_STATE] = state_en;
	assign pin_status[pbm_pkg::PBM_ST_ADDR_OK] = addr_valid;

	// port data reads show the synchronised pin, whatever drives it
	wire [7:0] rd_mux =
		sel_iface ? iface_cfg_reg :
		sel_f2 ? fifo_cfg_reg[0] :
		sel_f4 ? fifo_cfg_reg[1] :
		sel_f6 ? fifo_cfg_reg[2] :
		sel_f8 ? fifo_cfg_reg[3] :
		sel_csel ? port_c_sel_reg :
		sel_esel ? port_e_sel_reg :
		sel_db ? b_sync :
		sel_dc ? c_sync :
		sel_dd ? d_sync :
		sel_de ? e_sync :
		sel_ob ? oe_b_reg :
		sel_oc ? oe_c_reg :
		sel_od ? oe_d_reg :
		sel_oe ? oe_e_reg :
		sel_st ? pin_status :
		// a miss on every select reads as zero, so unmapped space is quiet
		8'h00;

	// both stages clear in reset, so pin reads show zero for two edges after it
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pin_meta_reg <= 32'h0000_0000;
			pin_sync_reg <= 32'h0000_0000;
		end
		else
		begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			iface_cfg_reg <= pbm_pkg::PBM_RESET_BYTE;
			port_c_sel_reg <= pbm_pkg::PBM_RESET_BYTE;
			port_e_sel_reg <= pbm_pkg::PBM_RESET_BYTE;
		end
		else if (reg_wr)
		begin
			// a write that matches no select is simply dropped
			if (sel_iface)
				iface_cfg_reg <= reg_wdata;
			if (sel_csel)
				port_c_sel_reg <= reg_wdata;
			if (sel_esel)
				port_e_sel_reg <= reg_wdata;
		end
	end

	generate
		for (f = 0; f < pbm_pkg::PBM_NUM_FIFOS; f++)
		begin : g_fcfg
			always_ff @(posedge mclk)
			begin
				if (srst)
					fifo_cfg_reg[f] <= pbm_pkg::PBM_RESET_BYTE;
				else if (reg_wr && sel_fifo[f])
					fifo_cfg_reg[f] <= fifo_wdata;
			end
		end
	endgenerate

	// port data and enable registers always store; whether they reach the
	// pin is decided per pin in the cells
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			data_b_reg <= pbm_pkg::PBM_RESET_BYTE;
			data_c_reg <= pbm_pkg::PBM_RESET_BYTE;
			data_d_reg <= pbm_pkg::PBM_RESET_BYTE;
			data_e_reg <= pbm_pkg::PBM_RESET_BYTE;
			oe_b_reg <= pbm_pkg::PBM_RESET_BYTE;
			oe_c_reg <= pbm_pkg::PBM_RESET_BYTE;
			oe_d_reg <= pbm_pkg::PBM_RESET_BYTE;
			oe_e_reg <= pbm_pkg::PBM_RESET_BYTE;
		end
		else if (reg_wr)
		begin
			if (sel_db)
				data_b_reg <= reg_wdata;
			if (sel_dc)
				data_c_reg <= reg_wdata;
			if (sel_dd)
				data_d_reg <= reg_wdata;
			if (sel_de)
				data_e_reg <= reg_wdata;
			if (sel_ob)
				oe_b_reg <= reg_wdata;
			if (sel_oc)
				oe_c_reg <= reg_wdata;
			if (sel_od)
				oe_d_reg <= reg_wdata;
			if (sel_oe)
				oe_e_reg <= reg_wdata;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk)
	begin
		if (srst)
			rdata_reg <= 8'h00;
		else if (reg_rd)
			rdata_reg <= rd_mux;
		else
			rdata_reg <= 8'h00;
	end
	assign reg_rdata = rdata_reg;

	// alternate inputs are fed from the pin even in gpio or output use,
	// so firmware driving pin 5 can raise its own interrupt
	assign ext_interrupt_six = e_sync[pbm_pkg::PBM_PE_EXT_INTERRUPT_SIX];
	assign timer2_external_input = e_sync[pbm_pkg::PBM_PE_TIMER2_EXTERNAL_INPUT];
	assign fifo_data_bus_in = {d_sync, b_sync};
	assign iface_mode_field = mode_field;
	assign fifo_16bit_sel = wide_bits;

	// each cell hands back one port's drive as a single carrier
	wire pbm_pkg::pbm_pin_s drive_b;
	wire pbm_pkg::pbm_pin_s drive_c;
	wire pbm_pkg::pbm_pin_s drive_d;
	wire pbm_pkg::pbm_pin_s drive_e;

	pbm_pin_cell #(
		.WIDTH(8)
	) u_cell_b (
		.mclk(mclk),
		.srst(srst),
		.alt_sel({8{b_fifo}}),
		.alt_val(fifo_data_bus_out[7:0]),
		.alt_drive({8{fifo_data_bus_drive}}),
		.gpio_val(data_b_reg),
		.gpio_oe(oe_b_reg),
		.pin_out(drive_b.out),
		.pin_oe_n(drive_b.oe_n)
	);

	pbm_pin_cell #(
		.WIDTH(8)
	) u_cell_c (
		.mclk(mclk),
		.srst(srst),
		.alt_sel(c_alt_sel),
		.alt_val(c_alt_val),
		.alt_drive(8'hff),
		.gpio_val(data_c_reg),
		.gpio_oe(oe_c_reg),
		.pin_out(drive_c.out),
		.pin_oe_n(drive_c.oe_n)
	);

	pbm_pin_cell #(
		.WIDTH(8)
	) u_cell_d (
		.mclk(mclk),
		.srst(srst),
		.alt_sel({8{d_fifo}}),
		.alt_val(fifo_data_bus_out[15:8]),
		.alt_drive({8{fifo_data_bus_drive}}),
		.gpio_val(data_d_reg),
		.gpio_oe(oe_d_reg),
		.pin_out(drive_d.out),
		.pin_oe_n(drive_d.oe_n)
	);

	pbm_pin_cell #(
		.WIDTH(8)
	) u_cell_e (
		.mclk(mclk),
		.srst(srst),
		.alt_sel(e_alt_sel),
		.alt_val(e_alt_val),
		.alt_drive(e_alt_drive),
		.gpio_val(data_e_reg),
		.gpio_oe(oe_e_reg),
		.pin_out(drive_e.out),
		.pin_oe_n(drive_e.oe_n)
	);

	assign port_b_out = drive_b.out;
	assign port_b_oe_n = drive_b.oe_n;
	assign port_c_out = drive_c.out;
	assign port_c_oe_n = drive_c.oe_n;
	assign port_d_out = drive_d.out;
	assign port_d_oe_n = drive_d.oe_n;
	assign port_e_out = drive_e.out;
	assign port_e_oe_n = drive_e.oe_n;
endmodule // pbm_port_mux

// >>> sim/pbm_port_mux_assertions.sv
// concurrent checks on the port mux top-level ports
`timescale 1ns/100ps
module pbm_chk (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] port_b_in,
	input wire logic [7:0] port_d_in,
	input wire logic [7:0] port_e_in,
	input wire logic [7:0] port_b_out,
	input wire logic [7:0] port_b_oe_n,
	input wire logic [7:0] port_d_out,
	input wire logic [15:0] fifo_data_bus_out,
	input wire logic fifo_data_bus_drive,
	input wire logic [15:0] fifo_data_bus_in,
	input wire logic ext_interrupt_six,
	input wire logic [1:0] iface_mode_field,
	input wire logic [3:0] fifo_16bit_sel
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	a_b_fifo_low: assert property (
		!$past(srst) && $past(iface_mode_field[1]) |-> port_b_out == $past(fifo_data_bus_out[7:0])
		&& port_b_oe_n == {8{!$past(fifo_data_bus_drive)}}) else $error("port b not on fifo bus");
	a_d_fifo_high: assert property (
		!$past(srst) && $past(iface_mode_field[1] && |fifo_16bit_sel)
		|-> port_d_out == $past(fifo_data_bus_out[15:8])) else $error("port d not on fifo bus");
	a_mode_write: assert property (
		reg_wr && reg_addr == pbm_pkg::PBM_ADDR_IFACE_CFG
		|=> iface_mode_field == $past(reg_wdata[1:0])) else $error("mode write lost");
	a_wide_write: assert property (
		reg_wr && reg_addr == pbm_pkg::PBM_ADDR_FIFO6_CFG
		|=> fifo_16bit_sel[2] == $past(reg_wdata[0])) else $error("word width write lost");
	a_wide_read: assert property (
		reg_rd && reg_addr == pbm_pkg::PBM_ADDR_FIFO2_CFG |=> reg_rdata[0] == $past(fifo_16bit_sel[0])
		&& reg_rdata[7] == 1'b0 && reg_rdata[1] == 1'b0) else $error("word width read wrong");
	a_ext_interrupt_six_listen: assert property (
		!$past(srst) && !$past(srst, 2) |-> ext_interrupt_six == $past(port_e_in[5], 2))
		else $error("interrupt input not following pin");
	a_fifo_in_pair: assert property (
		!$past(srst) && !$past(srst, 2) |-> fifo_data_bus_in == $past({port_d_in, port_b_in}, 2))
		else $error("fifo input bus mispaired");
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside its cycle");
endmodule // pbm_chk

// >>> sim/testbench.sv
// self-checking bench for the port b/c/d/e alternate-function mux
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, s); end end
module testbench;
	typedef struct packed {
		logic [7:0] ifc, pc, pe, b, d, c, e, eoe;
		logic [3:0] w;
	} pbm_row_s;
	// gpio data b=11 c=33 d=22 e=44, all outputs; fifo out beef, addr 1a5, state 5
	pbm_row_s rows [5] = '{
		'{8'h00, 8'h00, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 4'h1},
		'{8'h02, 8'hff, 8'h00, 8'hef, 8'h22, 8'ha5, 8'h44, 8'h00, 4'h0},
		'{8'h03, 8'h0f, 8'hff, 8'hef, 8'hbe, 8'h30, 8'h16, 8'h60, 4'h1},
		'{8'h06, 8'hf0, 8'h80, 8'hef, 8'hbe, 8'ha3, 8'hc5, 8'h00, 4'h8},
		'{8'h04, 8'h01, 8'h07, 8'h11, 8'h22, 8'h32, 8'h45, 8'h00, 4'h4}};
	logic mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, fifo_data_bus_drive = 1;
	logic [15:0] reg_addr = 0, fifo_data_bus_out = 16'hbeef, fifo_data_bus_in;
	logic [7:0] reg_wdata = 0, reg_rdata, v, port_b_in = 8'h3c, port_c_in = 8'h00;
	logic [7:0] port_d_in = 8'h96, port_e_in = 8'h00;
	logic [7:0] port_b_out, port_b_oe_n, port_c_out, port_c_oe_n;
	logic [7:0] port_d_out, port_d_oe_n, port_e_out, port_e_oe_n;
	logic [8:0] prog_iface_addr = 9'h1a5;
	logic [2:0] iface_state = 3'h5;
	pbm_pkg::pbm_alt_s alt_fn_out = 5'h16;
	logic ext_interrupt_six, timer2_external_input;
	logic [1:0] iface_mode_field;
	logic [3:0] fifo_16bit_sel;
	wire [39:0] rel_view = {port_b_oe_n, port_c_oe_n, port_d_oe_n, port_e_oe_n, port_b_out};
	pbm_row_s r;
	int err_count = 0, n_compared = 0, cyc = 0;
	pbm_port_mux dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_b_in(port_b_in),
		.port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n), .port_c_in(port_c_in),
		.port_c_out(port_c_out), .port_c_oe_n(port_c_oe_n), .port_d_in(port_d_in),
		.port_d_out(port_d_out), .port_d_oe_n(port_d_oe_n), .port_e_in(port_e_in),
		.port_e_out(port_e_out), .port_e_oe_n(port_e_oe_n),
		.fifo_data_bus_out(fifo_data_bus_out), .fifo_data_bus_drive(fifo_data_bus_drive),
		.fifo_data_bus_in(fifo_data_bus_in), .prog_iface_addr(prog_iface_addr),
		.iface_state(iface_state), .alt_fn_out(alt_fn_out),
		.ext_interrupt_six(ext_interrupt_six), .timer2_external_input(timer2_external_input),
		.iface_mode_field(iface_mode_field), .fifo_16bit_sel(fifo_16bit_sel));
	always #50 mclk = ~mclk;
	task automatic conclude;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [15:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic settle;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	// run needs about 150 cycles; the ceiling catches a hang
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			conclude();
		end
	end
	initial
	begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		settle();
		`CHK("reset", 40'hffffffff00, rel_view)
		wr(pbm_pkg::PBM_ADDR_DATA_B, 8'h11);
		wr(pbm_pkg::PBM_ADDR_DATA_C, 8'h33);
		wr(pbm_pkg::PBM_ADDR_DATA_D, 8'h22);
		wr(pbm_pkg::PBM_ADDR_DATA_E, 8'h44);
		for (int k = 0; k < 4; k++)
			wr(pbm_pkg::PBM_ADDR_OE_B + 16'(k), 8'hff);
		foreach (rows[i])
		begin
			r = rows[i];
			wr(pbm_pkg::PBM_ADDR_IFACE_CFG, r.ifc);
			wr(pbm_pkg::PBM_ADDR_PORT_C_SEL, r.pc);
			wr(pbm_pkg::PBM_ADDR_PORT_E_SEL, r.pe);
			// bits 7 and 1 are written high to see them read back as zero
			for (int k = 0; k < 4; k++)
				wr(pbm_pkg::PBM_ADDR_FIFO2_CFG + 16'(k), {7'h7f, r.w[k]});
			rd(pbm_pkg::PBM_ADDR_FIFO2_CFG);
			`CHK("fifo2 cfg", 8'h7c | {7'h00, r.w[0]}, v)
			settle();
			`CHK("width bits", r.w, fifo_16bit_sel)
			`CHK("mode", r.ifc[1:0], iface_mode_field)
			`CHK("port b", r.b, port_b_out)
			`CHK("port d", r.d, port_d_out)
			`CHK("port c", r.c, port_c_out)
			`CHK("port e", r.e, port_e_out & ~port_e_oe_n)
			`CHK("port e oe", r.eoe, port_e_oe_n)
		end
		wr(pbm_pkg::PBM_ADDR_IFACE_CFG, 8'h03);
		wr(pbm_pkg::PBM_ADDR_DATA_B, 8'h5a);
		wr(pbm_pkg::PBM_ADDR_OE_B, 8'h00);
		settle();
		`CHK("alt b", 16'hef00, {port_b_out, port_b_oe_n})
		@(posedge mclk);
		fifo_data_bus_drive <= 1'b0;
		settle();
		`CHK("alt b released", 8'hff, port_b_oe_n)
		rd(pbm_pkg::PBM_ADDR_DATA_B);
		`CHK("pin read", port_b_in, v)
		wr(pbm_pkg::PBM_ADDR_IFACE_CFG, 8'h00);
		settle();
		`CHK("gpio b", 16'h5aff, {port_b_out, port_b_oe_n})
		@(posedge mclk);
		port_e_in <= 8'h60;
		repeat (3) @(posedge mclk);
		#1;
		`CHK("ext_interrupt_six timer2_external_input", 2'h3, {timer2_external_input, ext_interrupt_six})
		`CHK("fifo in", 16'h963c, fifo_data_bus_in)
		rd(16'he600);
		`CHK("unmapped", 8'h00, v)
		// a reset in mid-run must release every pin and clear the registers
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		settle();
		`CHK("mid reset", 40'hffffffff00, rel_view)
		rd(pbm_pkg::PBM_ADDR_OE_C);
		`CHK("mid reset oe", 8'h00, v)
		conclude();
	end
endmodule // testbench
bind pbm_port_mux pbm_chk u_chk (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.port_b_in(port_b_in), .port_d_in(port_d_in), .port_e_in(port_e_in),
	.port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n), .port_d_out(port_d_out),
	.fifo_data_bus_out(fifo_data_bus_out), .fifo_data_bus_drive(fifo_data_bus_drive),
	.fifo_data_bus_in(fifo_data_bus_in), .ext_interrupt_six(ext_interrupt_six),
	.iface_mode_field(iface_mode_field), .fifo_16bit_sel(fifo_16bit_sel));
